// File: logic/sebp_pkg.sv
// package: constants, state encodings and state records of the two-wire memory target
package sebp_pkg;

  // ==========================================================================
  // framing
  // ==========================================================================
  localparam int unsigned WORD_BITS    = 8;       // bits in one bus word
  localparam logic [3:0]  ADDR_PATTERN = 4'ha;    // fixed top nibble of the address word
  localparam logic [3:0]  BIT_LAST     = 4'h7;    // count while the eighth bit is taken
  localparam logic [3:0]  BIT_ACK      = 4'h8;    // count during the ninth (acknowledge) clock
  localparam logic [3:0]  BIT_FIRST    = 4'h1;    // count after the first bit of a word
  localparam logic        SDA_IDLE     = 1'b1;    // released line level seen through pull-up

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ             = 25_000_000;
  localparam int unsigned WRITE_INTERVAL_MS  = 5;
  // a longest time, so the division rounds down
  localparam int unsigned WRITE_INTERVAL_CYC = CLK_HZ / 1000 * WRITE_INTERVAL_MS;
  localparam int unsigned WR_CNT_W           = $clog2(WRITE_INTERVAL_CYC + 1);
  localparam int unsigned SYNC_W             = 5; // scl, sda, rx toggle, take toggle, write flag

  // ==========================================================================
  // state encodings
  // ==========================================================================
  typedef enum logic [3:0]
  {
    PH_IDLE  = 4'b0001,
    PH_ADDR  = 4'b0010,
    PH_WRITE = 4'b0100,
    PH_READ  = 4'b1000
  } sebp_phase_t;

  typedef enum logic [2:0]
  {
    ST_STANDBY = 3'b001,
    ST_ACTIVE  = 3'b010,
    ST_WRITING = 3'b100
  } sebp_state_t;

  // link state taken on the rising serial clock
  typedef struct packed
  {
    sebp_phase_t    phase;
    logic [3:0]     bitcnt;
    logic [7:0]     shreg;
    logic [7:0]     txsh;
    logic [7:0]     rx_word;
    logic           sda_pos;
    logic           addr_ok;
    logic           rw;
    logic           got_word;
    logic           wr_pend;
    logic           rx_tog;
    logic           take_tog;
  } sebp_rise_t;

  // link state taken on the falling serial clock
  typedef struct packed
  {
    logic           start;
    logic           oe;
  } sebp_fall_t;

  // system clock state
  typedef struct packed
  {
    sebp_state_t    state;
    logic [WR_CNT_W-1:0] cnt;
    logic           link_clr;
    logic           scl_d;
    logic           sda_d;
    logic           rx_seen;
    logic           take_seen;
    logic [7:0]     rx_data;
    logic           rx_valid;
    logic [7:0]     tx_hold;
    logic           tx_next;
    logic           commit;
  } sebp_core_t;

  // scl stayed high across a transition of sda from prev to now (falling sense)
  function automatic logic bus_cond(input logic scl_prev, input logic scl_now,
                                    input logic sda_prev, input logic sda_now);
    bus_cond = scl_prev & scl_now & sda_prev & ~sda_now;
  endfunction

endpackage

// File: logic/sebp_sync.sv
// two flip-flop level synchroniser into the system clock
`timescale 1ns/1ps
module sebp_sync
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic [W-1:0]      q_o
);

  // ==========================================================================
  // two stages; the first is read by the second only
  // ==========================================================================
  logic [W-1:0] meta;
  logic [W-1:0] stab;

  // reset to zero; callers whose lines idle high see a stop-free start-up
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      stab <= '0;
    end
    else
    begin
      meta <= d_i;
      stab <= meta;
    end
  end

  assign q_o = stab;

endmodule

// File: logic/sebp_target.sv
// two-wire serial memory target: framing on the bus clock, conditions and write timer on clk_i
`timescale 1ns/1ps

// Behaviour
// - sda may change only while scl is low, and a change while scl is high is start or stop.
// - sda falling while scl is high is a start, which opens a new transfer.
// - sda rising while scl is high is a stop, which the target detects to end a transfer.
// - a stop that ends a read sequence puts the target into standby.
// - words are 8 bits and every word received for a matching address nibble is acknowledged by a low sda in clock nine.
// - standby holds at power-up and after a stop once any internal operation is done.
// - the internal write interval starts at a stop closing a write and ends within 5 ms.
// - incoming bits are taken on scl rising and outgoing bits change on scl falling.
// - while the write interval runs all bus activity is ignored and nothing is acknowledged.
module sebp_target
  import sebp_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_INTERVAL_CYC
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_next_o,
  output logic            commit_o,
  output logic            busy_o,
  output logic            standby_o
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  sebp_rise_t          lr;
  sebp_rise_t          next_lr;
  sebp_fall_t          lf;
  sebp_fall_t          next_lf;
  sebp_core_t          core;
  sebp_core_t          next_core;
  logic [7:0]          new_sh;
  logic                link_rst;
  logic [SYNC_W-1:0]   sync_q;
  logic                scl_s;
  logic                sda_s;
  logic                rx_tog_s;
  logic                take_tog_s;
  logic                wr_pend_s;
  logic                start_det;
  logic                stop_det;

  localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(WRITE_CYCLES - 1);

  // the link side is held cleared from a stop until the next start, and for the whole
  // write interval; a stop leaves scl high with no edge to clear anything by itself
  assign link_rst = rst_i | core.link_clr;

  // open drain: the data output is always low, only its enable moves
  assign sda_o = 1'b0;

  // ==========================================================================
  // link side, rising serial clock: take bits and frame words
  // ==========================================================================
  assign new_sh = {lr.shreg[6:0], sda_i};

  always_comb
  begin
    next_lr = lr;
    next_lr.sda_pos = sda_i;
    if (lf.start)
    begin
      // a start seen in the high phase just ended: drop any partial word
      next_lr.phase    = PH_ADDR;
      next_lr.shreg    = new_sh;
      next_lr.bitcnt   = BIT_FIRST;
      next_lr.addr_ok  = 1'b0;
      next_lr.got_word = 1'b0;
      next_lr.wr_pend  = 1'b0;
    end
    else
    begin
      case (lr.phase)
        PH_ADDR:
        begin
          if (lr.bitcnt != BIT_ACK)
          begin
            next_lr.shreg  = new_sh;
            next_lr.bitcnt = lr.bitcnt + 4'h1;
            if (lr.bitcnt == BIT_LAST)
            begin
              // the master keeps the fixed nibble; a mismatch gets no answer
              next_lr.addr_ok = (new_sh[7:4] == ADDR_PATTERN);
              next_lr.rw      = new_sh[0];
            end
          end
          else
          begin
            next_lr.bitcnt = 4'h0;
            if (!lr.addr_ok)
            begin
              next_lr.phase = PH_IDLE;
            end
            else if (lr.rw)
            begin
              // first read byte is taken from the hold register and a refill is asked
              next_lr.phase    = PH_READ;
              next_lr.txsh     = core.tx_hold;
              next_lr.take_tog = ~lr.take_tog;
            end
            else
            begin
              next_lr.phase = PH_WRITE;
            end
          end
        end
        PH_WRITE:
        begin
          if (lr.bitcnt != BIT_ACK)
          begin
            next_lr.shreg  = new_sh;
            next_lr.bitcnt = lr.bitcnt + 4'h1;
            if (lr.bitcnt == BIT_LAST)
            begin
              // word address then data: a second word makes this a real write
              next_lr.rx_word  = new_sh;
              next_lr.rx_tog   = ~lr.rx_tog;
              next_lr.got_word = 1'b1;
              next_lr.wr_pend  = lr.got_word | lr.wr_pend;
            end
          end
          else
          begin
            next_lr.bitcnt = 4'h0;
          end
        end
        PH_READ:
        begin
          if (lr.bitcnt != BIT_ACK)
          begin
            next_lr.bitcnt = lr.bitcnt + 4'h1;
          end
          else if (!sda_i)
          begin
            // master acknowledged: carry on with the next byte
            next_lr.bitcnt   = 4'h0;
            next_lr.txsh     = core.tx_hold;
            next_lr.take_tog = ~lr.take_tog;
          end
          else
          begin
            // no acknowledge: stay off the line until stop or start
            next_lr.phase  = PH_IDLE;
            next_lr.bitcnt = 4'h0;
          end
        end
        default:
        begin
          next_lr.bitcnt = 4'h0;
        end
      endcase
    end
  end

  // sda_pos resets high so the first start after a clear is always recognised
  always_ff @(posedge scl_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      lr          <= '0;
      lr.phase    <= PH_IDLE;
      lr.sda_pos  <= SDA_IDLE;
    end
    else
    begin
      lr <= next_lr;
    end
  end

  // ==========================================================================
  // link side, falling serial clock: start check and line drive
  // ==========================================================================
  always_comb
  begin
    next_lf = '0;
    // high at the rising edge, low now: sda fell while scl was high
    next_lf.start = lr.sda_pos & ~sda_i;
    if (!next_lf.start)
    begin
      case (lr.phase)
        PH_ADDR:
        begin
          next_lf.oe = (lr.bitcnt == BIT_ACK) & lr.addr_ok;
        end
        PH_WRITE:
        begin
          next_lf.oe = (lr.bitcnt == BIT_ACK);
        end
        PH_READ:
        begin
          // shift out on the falling edge, msb first; pull low for a zero only
          next_lf.oe = (lr.bitcnt < BIT_ACK) & ~lr.txsh[3'd7 - lr.bitcnt[2:0]];
        end
        default:
        begin
          next_lf.oe = 1'b0;
        end
      endcase
    end
  end

  // held cleared during the write interval, so nothing is ever acknowledged then
  always_ff @(negedge scl_i or posedge link_rst)
  begin
    if (link_rst)
    begin
      lf <= '0;
    end
    else
    begin
      lf <= next_lf;
    end
  end

  assign sda_oe_o = lf.oe;

  // ==========================================================================
  // crossings into the system clock
  // ==========================================================================
  sebp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i, lr.rx_tog, lr.take_tog, lr.wr_pend}),
    .q_o   (sync_q)
  );

  assign scl_s      = sync_q[4];
  assign sda_s      = sync_q[3];
  assign rx_tog_s   = sync_q[2];
  assign take_tog_s = sync_q[1];
  assign wr_pend_s  = sync_q[0];

  // start: sda fell with scl high; stop: the same with sda inverted
  assign start_det = bus_cond(core.scl_d, scl_s, core.sda_d, sda_s);
  assign stop_det  = bus_cond(core.scl_d, scl_s, ~core.sda_d, ~sda_s);

  // ==========================================================================
  // system clock: standby, write interval and user hand-off
  // ==========================================================================
  always_comb
  begin
    next_core          = core;
    next_core.scl_d    = scl_s;
    next_core.sda_d    = sda_s;
    next_core.rx_valid = 1'b0;
    next_core.tx_next  = 1'b0;
    next_core.commit   = 1'b0;
    next_core.rx_seen   = rx_tog_s;
    next_core.take_seen = take_tog_s;

    // a received word stays put in the link for nine more bus clocks, long enough to copy;
    // clearing the link drops its toggles to zero, which must not read as a new word
    if ((rx_tog_s != core.rx_seen) && !core.link_clr)
    begin
      next_core.rx_data  = lr.rx_word;
      next_core.rx_valid = 1'b1;
    end

    // the hold register follows the user, who moves on only after a take, so it has
    // settled long before the link's next take nine bus clocks later
    next_core.tx_hold = tx_data_i;
    // the link took the hold register: ask for the following byte, unless the toggle
    // moved only because a stop cleared the link
    if ((take_tog_s != core.take_seen) && !core.link_clr)
    begin
      next_core.tx_next = 1'b1;
    end

    case (core.state)
      ST_STANDBY, ST_ACTIVE:
      begin
        if (stop_det)
        begin
          next_core.link_clr = 1'b1;
          if ((core.state == ST_ACTIVE) && wr_pend_s)
          begin
            next_core.state  = ST_WRITING;
            next_core.cnt    = '0;
            next_core.commit = 1'b1;
          end
          else
          begin
            next_core.state = ST_STANDBY;
          end
        end
        else if (start_det)
        begin
          // release the link while scl is still high, before its first falling edge
          next_core.state    = ST_ACTIVE;
          next_core.link_clr = 1'b0;
        end
      end
      ST_WRITING:
      begin
        // starts and stops here are polling attempts and are left unanswered
        next_core.link_clr = 1'b1;
        if (core.cnt == WR_LAST)
        begin
          next_core.state = ST_STANDBY;
          next_core.cnt   = '0;
        end
        else
        begin
          next_core.cnt = core.cnt + 1'b1;
        end
      end
      default:
      begin
        next_core.state    = ST_STANDBY;
        next_core.link_clr = 1'b1;
      end
    endcase
  end

  // power-up lands in standby with the link held clear until the first start
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      core          <= '0;
      core.state    <= ST_STANDBY;
      core.link_clr <= 1'b1;
    end
    else
    begin
      core <= next_core;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign rx_data_o  = core.rx_data;
  assign rx_valid_o = core.rx_valid;
  assign tx_next_o  = core.tx_next;
  assign commit_o   = core.commit;
  assign busy_o     = (core.state == ST_WRITING);
  assign standby_o  = (core.state == ST_STANDBY);

endmodule

// File: bench/sebp_target_asserts.sv
// port assertions for the two-wire memory target
`timescale 1ns/1ps
module sebp_target_asserts
#(
  parameter int unsigned WRITE_CYCLES = 125000
)
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_valid_o,
  input wire logic [7:0] tx_data_i,
  input wire logic       tx_next_o,
  input wire logic       commit_o,
  input wire logic       busy_o,
  input wire logic       standby_o
);
  logic [17:0] busy_len;

  // ==========================================
  // interval length, judged when busy drops
  // ==========================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      busy_len <= 18'h0;
    else if (busy_o)
      busy_len <= busy_len + 18'h1;
    else
      busy_len <= 18'h0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // scl seen high on two samples in a row
  sequence s_held_high;
    $past(scl_i) && scl_i;
  endsequence

  sequence s_busy_soon;
    ##[0:2] busy_o;
  endsequence

  drive_low_only_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  hold_while_high_a: assert property (s_held_high |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
  quiet_when_busy_a: assert property (busy_o |-> !sda_oe_o)
    else $error("answer during write interval");
  interval_open_a: assert property (commit_o |-> s_busy_soon)
    else $error("no interval after commit");
  interval_len_a: assert property ($fell(busy_o) |->
    ({14'h0, busy_len} >= WRITE_CYCLES - 1 && {14'h0, busy_len} <= WRITE_CYCLES))
    else $error("write interval length wrong");
  interval_hold_a: assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("write interval cut short");
  standby_after_a: assert property ($fell(busy_o) |-> standby_o)
    else $error("no standby after interval");
  rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("word strobe too long");
  tx_pulse_a: assert property (tx_next_o |=> !tx_next_o)
    else $error("send strobe too long");
endmodule

bind sebp_target sebp_target_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk
(
  .clk_i      (clk_i),
  .rst_i      (rst_i),
  .scl_i      (scl_i),
  .sda_i      (sda_i),
  .sda_o      (sda_o),
  .sda_oe_o   (sda_oe_o),
  .rx_data_o  (rx_data_o),
  .rx_valid_o (rx_valid_o),
  .tx_data_i  (tx_data_i),
  .tx_next_o  (tx_next_o),
  .commit_o   (commit_o),
  .busy_o     (busy_o),
  .standby_o  (standby_o)
);

// File: bench/sebp_master.sv
// bus master model: clocks frames and pulls the open-drain data wire low
`timescale 1ns/1ps
module sebp_master
(
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ==========================================
  // idle: clock parked high, data released
  // ==========================================
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // odd offset keeps link edges off clk_i edges; sda released before scl rises for a repeat
  task automatic start_c();
    #1.3;
    sda_low_o = 1'b0;
    #20;
    scl_o = 1'b1;
    #200;
    sda_low_o = 1'b1;
    #200;
    scl_o = 1'b0;
  endtask

  task automatic stop_c();
    #21.3;
    sda_low_o = 1'b1;
    #20;
    scl_o = 1'b1;
    #200;
    sda_low_o = 1'b0;
    #200;
  endtask

  // data set in the low phase, sampled mid-high, 125 ns a clock
  task automatic bit_c(input logic b, output logic r);
    #20;
    sda_low_o = ~b;
    #42.5;
    scl_o = 1'b1;
    #31.25;
    r = sda_i;
    #31.25;
    scl_o = 1'b0;
  endtask

  task automatic byte_c(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_c(d[i], r);
      q[i] = r;
    end
    bit_c(ak, ack);
  endtask

  // clock until data reads high with scl high, then start in that same high
  task automatic recover_c(output int n);
    n = 0;
    sda_low_o = 1'b0;
    while (n < 9)
    begin
      #62.5;
      scl_o = 1'b1;
      n++;
      #31.25;
      if (sda_i === 1'b1)
        break;
      #31.25;
      scl_o = 1'b0;
    end
    scl_o = 1'b1;
    #200;
    sda_low_o = 1'b1;
    #200;
    scl_o = 1'b0;
  endtask
endmodule

// File: bench/testbench.sv
// self-checking bench of the two-wire memory target
`timescale 1ns/1ps
module testbench;
  localparam int unsigned WR = 200; // short interval keeps the run brief
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       scl;
  logic       low;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic [7:0] tx_data = 8'h1e; // first byte of the read stream
  logic       tx_next;
  logic       commit;
  logic       busy;
  logic       standby;
  int         fail_count = 0;
  int         n_compared = 0;
  int         n_commit = 0;
  int         n_txn = 0;
  int         busy_cyc = 0;
  logic [7:0] rxq[$];

  always #20 clk = ~clk;
  // wire with pull-up: low while either party pulls
  assign sda_w = ~((sda_oe & ~sda_o) | low);

  sebp_master u_mst (.sda_i(sda_w), .scl_o(scl), .sda_low_o(low));

  sebp_target #(.WRITE_CYCLES(WR)) u_dut
  (
    .clk_i      (clk),
    .rst_i      (rst),
    .scl_i      (scl),
    .sda_i      (sda_w),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe),
    .rx_data_o  (rx_data),
    .rx_valid_o (rx_valid),
    .tx_data_i  (tx_data),
    .tx_next_o  (tx_next),
    .commit_o   (commit),
    .busy_o     (busy),
    .standby_o  (standby)
  );

  // ==========================================
  // user-side monitor; read stream steps by 0x11
  // ==========================================
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
      rxq.push_back(rx_data);
    if (commit === 1'b1)
      n_commit++;
    if (busy === 1'b1)
      busy_cyc++;
    if (tx_next === 1'b1)
    begin
      n_txn++;
      tx_data <= tx_data + 8'h11;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic t_reset_state();
    chk({7'h0, standby}, 8'h01);
    chk({6'h0, busy, sda_oe}, 8'h00);
    chk({7'h0, sda_o}, 8'h00);
    chk(rx_data, 8'h00);
  endtask

  // write, poll during the interval, poll again once it ends
  task automatic t_write_poll();
    logic [7:0] q;
    logic       a;
    int         n;
    rxq.delete();
    n = n_commit;
    busy_cyc = 0;
    u_mst.start_c();
    u_mst.byte_c(8'ha0, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    chk({7'h0, standby}, 8'h00);
    u_mst.byte_c(8'h5c, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_mst.byte_c(8'ha5, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_mst.stop_c();
    chk(8'(rxq.size()), 8'h02);
    chk(rxq[0], 8'h5c);
    chk(rxq[1], 8'ha5);
    chk(8'(n_commit - n), 8'h01);
    chk({7'h0, busy}, 8'h01);
    u_mst.start_c();
    u_mst.byte_c(8'ha1, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    u_mst.stop_c();
    for (int i = 0; i < WR + 20 && busy === 1'b1; i++)
      @(negedge clk);
    chk({6'h0, busy, busy_cyc <= WR}, 8'h01);
    chk({7'h0, standby}, 8'h01);
    u_mst.start_c();
    u_mst.byte_c(8'ha0, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_mst.stop_c();
    chk(8'(n_commit - n), 8'h01);
  endtask

  // foreign top nibble: nothing answered until the next start
  task automatic t_bad_addr();
    logic [7:0] q;
    logic       a;
    int         n;
    rxq.delete();
    n = n_commit;
    u_mst.start_c();
    u_mst.byte_c(8'h30, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    u_mst.byte_c(8'h5c, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    u_mst.stop_c();
    chk(8'(rxq.size()), 8'h00);
    chk({7'h0, standby}, 8'h01);
    chk(8'(n_commit - n), 8'h00);
  endtask

  // restart inside a word, read one byte, recover the bus mid-way through the next, then a one-byte read
  task automatic t_restart_read();
    logic [7:0] q;
    logic       a;
    int         n;
    int         k;
    rxq.delete();
    n = n_txn;
    u_mst.start_c();
    u_mst.byte_c(8'ha0, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    for (int i = 0; i < 4; i++)
      u_mst.bit_c(1'b0, a);
    u_mst.start_c();
    u_mst.byte_c(8'ha1, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_mst.byte_c(8'hff, 1'b0, q, a);
    chk(q, 8'h1e);
    u_mst.recover_c(k);
    chk(8'(k), 8'h03);
    u_mst.stop_c();
    chk({7'h0, standby}, 8'h01);
    chk(8'(n_txn - n), 8'h02);
    chk(8'(rxq.size()), 8'h00);
    u_mst.start_c();
    u_mst.byte_c(8'ha1, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_mst.byte_c(8'hff, 1'b1, q, a);
    u_mst.stop_c();
    chk(q, 8'h40);
    chk(8'(n_txn - n), 8'h03);
    chk({7'h0, standby}, 8'h01);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_state();
    t_write_poll();
    t_bad_addr();
    t_restart_read();
    end_sim();
  end

  // the tests need some 27 us; fifteen times that means a hang
  initial
  begin
    #400_000;
    fail_count++;
    end_sim();
  end
endmodule
